// File: logic/bridge_defs.vh
/*
  Register map, field positions, reset values and timing counts of the
  bridge mode and fault logic.
  Assumes a 40 MHz core clock; included by bare name.
*/
`ifndef BRIDGE_DEFS_VH
`define BRIDGE_DEFS_VH

// ----------------------------------------------------------------
// Clock and times
// ----------------------------------------------------------------
`define CLK_MHZ            40
`define DEAD_TIME_NS       500
`define DEAD_TIME_CYC      ((`DEAD_TIME_NS * `CLK_MHZ + 999) / 1000)
`define OC_TIME_NS         1600
`define OC_TIME_CYC        ((`OC_TIME_NS * `CLK_MHZ + 999) / 1000)

// ----------------------------------------------------------------
// Register byte offsets
// ----------------------------------------------------------------
`define REG_DEAD_OFS       5'h00
`define REG_OCTIME_OFS     5'h04
`define REG_STATUS_OFS     5'h08
`define REG_MASK_OFS       5'h0c
`define REG_STATE_OFS      5'h10

// ----------------------------------------------------------------
// Field positions (status, mask and state share bits 3:0)
// ----------------------------------------------------------------
`define FLD_UV             0
`define FLD_OV             1
`define FLD_TH             2
`define FLD_OC             3
`define FLD_LEG_A          4
`define FLD_LEG_B          6
`define FLD_ALERT          8

// ----------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------
`define RST_MASK           4'h0
`define RST_STATUS         4'h0

// ----------------------------------------------------------------
// Leg requests
// ----------------------------------------------------------------
`define LEG_OFF            2'h0
`define LEG_LOW            2'h1
`define LEG_HIGH           2'h2

`endif

// File: logic/leg_driver.v
/*
  One half-bridge leg: gate enables for the upper and lower transistor,
  with a dead gap whenever conduction passes from one to the other.
  Assumes the request changes synchronously to core_clk_i.
*/
`timescale 1ns/1ps
`default_nettype none
`include "bridge_defs.vh"

module leg_driver #(
  parameter DW = 16
) (
  // Clock and reset
  input  wire          core_clk_i,
  input  wire          arst_n_i,
  // Request
  input  wire [1:0]    leg_req_i,
  input  wire [DW-1:0] dead_cyc_i,
  // Gates
  output reg           hi_on_o,
  output reg           lo_on_o
);

  reg [DW-1:0] gap_r;

  // ----------------------------------------------------------------
  // Break before make
  // ----------------------------------------------------------------
  always @(posedge core_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      hi_on_o <= 1'b0;
      lo_on_o <= 1'b0;
      gap_r   <= {DW{1'b0}};
    end else begin
      case (leg_req_i)
        `LEG_HIGH: begin
          if (lo_on_o) begin
            lo_on_o <= 1'b0;
            gap_r   <= dead_cyc_i;
          end else if (gap_r != {DW{1'b0}}) begin
            gap_r <= gap_r - 1'b1;
          end else begin
            hi_on_o <= 1'b1;
          end
        end
        `LEG_LOW: begin
          if (hi_on_o) begin
            hi_on_o <= 1'b0;
            gap_r   <= dead_cyc_i;
          end else if (gap_r != {DW{1'b0}}) begin
            gap_r <= gap_r - 1'b1;
          end else begin
            lo_on_o <= 1'b1;
          end
        end
        default: begin
          // Off is immediate; the gap still runs so a later turn-on waits
          hi_on_o <= 1'b0;
          lo_on_o <= 1'b0;
          if (hi_on_o || lo_on_o) begin
            gap_r <= dead_cyc_i;
          end else if (gap_r != {DW{1'b0}}) begin
            gap_r <= gap_r - 1'b1;
          end
        end
      endcase
    end
  end

endmodule
`default_nettype wire

// File: logic/bridge_ctrl.v
/*
  Full-bridge mode decode, protection latches, open-drain alert and an
  Avalon-MM register slave with a level interrupt.
  Assumes all pins are synchronous to core_clk_i and that the supply and
  temperature comparators deliver digital flags.
*/
// Implementation choices: the Avalon-MM interface to the registers and the placing of the registers.
`timescale 1ns/1ps
`default_nettype none
`include "bridge_defs.vh"

module bridge_ctrl #(
  parameter DW = 16
) (
  // Clock and reset
  input  wire          core_clk_i,
  input  wire          arst_n_i,
  // Host control pins
  input  wire          direction_input_a_i,
  input  wire          direction_input_b_i,
  input  wire          speed_i,
  // Protection comparators
  input  wire          supply_below_low_i,
  input  wire          supply_above_rec_i,
  input  wire          supply_above_high_i,
  input  wire          supply_below_rec_i,
  input  wire          over_temp_i,
  input  wire [3:0]    over_current_i,
  // Bridge gates
  output wire          bridge_output_a_hi_o,
  output wire          bridge_output_a_lo_o,
  output wire          bridge_output_b_hi_o,
  output wire          bridge_output_b_lo_o,
  // Open-drain alert
  output wire          alert_o,
  output reg           alert_oe_o,
  // Avalon-MM slave
  input  wire [4:0]    avs_address,
  input  wire          avs_read,
  input  wire          avs_write,
  input  wire [31:0]   avs_writedata,
  output reg  [31:0]   avs_readdata,
  output wire          avs_waitrequest,
  // Interrupt
  output wire          irq_o
);

  // ----------------------------------------------------------------
  // Reset values at register width
  // ----------------------------------------------------------------
  // The timing counts are plain integers; sizing them here keeps the
  // reset branch free of silent truncation when DW is narrowed.
  localparam [DW-1:0] dead_rst    = `DEAD_TIME_CYC;
  localparam [DW-1:0] oc_time_rst = `OC_TIME_CYC;

  // ----------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------
  reg  [DW-1:0] dead_cyc_r;
  reg  [DW-1:0] oc_time_r;
  reg  [3:0]    status_r;
  reg  [3:0]    status_nxt;
  reg  [3:0]    mask_r;
  reg           uv_r;
  reg           ov_r;
  reg           th_r;
  reg           oc_r;
  reg  [3:0]    flags_d_r;
  reg           ack_r;
  reg  [1:0]    leg_a_nxt;
  reg  [1:0]    leg_b_nxt;
  reg  [1:0]    leg_a_r;
  reg  [1:0]    leg_b_r;
  reg  [31:0]   rdata_nxt;
  wire          stop_req;
  wire          fault;
  wire [3:0]    flags;
  wire [3:0]    oc_trip;
  wire          bus_req;
  wire          bus_take;
  wire          status_rd;

  assign stop_req = ~direction_input_a_i & ~direction_input_b_i;
  assign flags    = {oc_r, th_r, ov_r, uv_r};
  assign fault    = |flags;

  // ----------------------------------------------------------------
  // Supply lockouts with hysteresis
  // ----------------------------------------------------------------
  // Hysteresis is held here: set on the outer threshold, cleared on the
  // recovery one, so comparator chatter between them does not toggle.
  always @(posedge core_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      uv_r <= 1'b0;
      ov_r <= 1'b0;
    end else begin
      if (supply_below_low_i) begin
        uv_r <= 1'b1;
      end else if (supply_above_rec_i) begin
        uv_r <= 1'b0;
      end
      if (supply_above_high_i) begin
        ov_r <= 1'b1;
      end else if (supply_below_rec_i) begin
        ov_r <= 1'b0;
      end
    end
  end

  // ----------------------------------------------------------------
  // Overcurrent persistence, one timer per transistor
  // ----------------------------------------------------------------
  // The counter saturates, so a long overcurrent never wraps below the limit.
  genvar gi;
  generate
    for (gi = 0; gi < 4; gi = gi + 1) begin : g_oc
      reg [DW-1:0] oc_cnt_r;
      always @(posedge core_clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
          oc_cnt_r <= {DW{1'b0}};
        end else if (!over_current_i[gi]) begin
          oc_cnt_r <= {DW{1'b0}};
        end else if (oc_cnt_r != {DW{1'b1}}) begin
          oc_cnt_r <= oc_cnt_r + 1'b1;
        end
      end
      assign oc_trip[gi] = over_current_i[gi] && (oc_cnt_r >= oc_time_r);
    end
  endgenerate

  // ----------------------------------------------------------------
  // Latched shutdowns
  // ----------------------------------------------------------------
  // A fault present in the clearing cycle stays latched: set wins.
  always @(posedge core_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      th_r <= 1'b0;
      oc_r <= 1'b0;
    end else begin
      if (over_temp_i) begin
        th_r <= 1'b1;
      end else if (stop_req) begin
        th_r <= 1'b0;
      end
      if (|oc_trip) begin
        oc_r <= 1'b1;
      end else if (stop_req) begin
        oc_r <= 1'b0;
      end
    end
  end

  // ----------------------------------------------------------------
  // Mode decode
  // ----------------------------------------------------------------
  // Priority is fault, then stop, then brake, then drive; a fault never
  // lets a leg conduct, whatever the pins ask for.
  always @* begin
    leg_a_nxt = `LEG_OFF;
    leg_b_nxt = `LEG_OFF;
    if (fault) begin
      leg_a_nxt = `LEG_OFF;
      leg_b_nxt = `LEG_OFF;
    end else if (stop_req) begin
      leg_a_nxt = `LEG_OFF;
      leg_b_nxt = `LEG_OFF;
    end else if ((direction_input_a_i && direction_input_b_i) || !speed_i) begin
      leg_a_nxt = `LEG_LOW;
      leg_b_nxt = `LEG_LOW;
    end else if (direction_input_a_i) begin
      leg_a_nxt = `LEG_HIGH;
      leg_b_nxt = `LEG_LOW;
    end else begin
      leg_a_nxt = `LEG_LOW;
      leg_b_nxt = `LEG_HIGH;
    end
  end

  always @(posedge core_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      leg_a_r <= `LEG_OFF;
      leg_b_r <= `LEG_OFF;
    end else begin
      leg_a_r <= leg_a_nxt;
      leg_b_r <= leg_b_nxt;
    end
  end

  // ----------------------------------------------------------------
  // Bridge legs
  // ----------------------------------------------------------------
  // Both legs share one dead count; a new value applies from the next gap.
  leg_driver #(
    .DW         (DW)
  ) u_leg_a (
    .core_clk_i (core_clk_i),
    .arst_n_i   (arst_n_i),
    .leg_req_i  (leg_a_r),
    .dead_cyc_i (dead_cyc_r),
    .hi_on_o    (bridge_output_a_hi_o),
    .lo_on_o    (bridge_output_a_lo_o)
  );

  leg_driver #(
    .DW         (DW)
  ) u_leg_b (
    .core_clk_i (core_clk_i),
    .arst_n_i   (arst_n_i),
    .leg_req_i  (leg_b_r),
    .dead_cyc_i (dead_cyc_r),
    .hi_on_o    (bridge_output_b_hi_o),
    .lo_on_o    (bridge_output_b_lo_o)
  );

  // ----------------------------------------------------------------
  // Alert pin
  // ----------------------------------------------------------------
  // Pin data is held low; only the enable moves, so it never drives high.
  assign alert_o = 1'b0;

  // Reset leaves the pin pulled low: no protection function is active yet.
  always @(posedge core_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      alert_oe_o <= 1'b1;
    end else if (fault) begin
      alert_oe_o <= 1'b0;
    end else begin
      alert_oe_o <= 1'b1;
    end
  end

  // ----------------------------------------------------------------
  // Avalon-MM slave
  // ----------------------------------------------------------------
  // Fixed one wait state; the answer is taken on the second edge.
  // A request dropped before its taking edge leaves no side effect.
  assign bus_req         = avs_read | avs_write;
  assign avs_waitrequest = bus_req & ~ack_r;
  assign bus_take        = bus_req & ack_r;

  always @* begin
    rdata_nxt = 32'h0000_0000;
    case (avs_address)
      `REG_DEAD_OFS:   rdata_nxt[DW-1:0] = dead_cyc_r;
      `REG_OCTIME_OFS: rdata_nxt[DW-1:0] = oc_time_r;
      `REG_STATUS_OFS: rdata_nxt[3:0]    = status_r;
      `REG_MASK_OFS:   rdata_nxt[3:0]    = mask_r;
      `REG_STATE_OFS: begin
        rdata_nxt[3:0]                   = flags;
        rdata_nxt[`FLD_LEG_A+1:`FLD_LEG_A] = leg_a_r;
        rdata_nxt[`FLD_LEG_B+1:`FLD_LEG_B] = leg_b_r;
        rdata_nxt[`FLD_ALERT]            = ~alert_oe_o;
      end
      default:         rdata_nxt = 32'h0000_0000;
    endcase
  end

  always @(posedge core_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      ack_r        <= 1'b0;
      avs_readdata <= 32'h0000_0000;
    end else begin
      ack_r <= avs_waitrequest;
      // Captured in the wait cycle, so it stands at the taking edge
      if (avs_read && !ack_r) begin
        avs_readdata <= rdata_nxt;
      end
    end
  end

  // ----------------------------------------------------------------
  // Configuration registers
  // ----------------------------------------------------------------
  // Writes land only on the taking edge; status and state ignore them.
  always @(posedge core_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      dead_cyc_r <= dead_rst;
      oc_time_r  <= oc_time_rst;
      mask_r     <= `RST_MASK;
    end else begin
      if (avs_write && ack_r) begin
        case (avs_address)
          `REG_DEAD_OFS:   dead_cyc_r <= (avs_writedata[DW-1:0] == {DW{1'b0}}) ?
                                         {{(DW-1){1'b0}}, 1'b1} : avs_writedata[DW-1:0];
          `REG_OCTIME_OFS: oc_time_r  <= avs_writedata[DW-1:0];
          `REG_MASK_OFS:   mask_r     <= avs_writedata[3:0];
          default:         mask_r     <= mask_r;
        endcase
      end
    end
  end

  // ----------------------------------------------------------------
  // Event status and interrupt
  // ----------------------------------------------------------------
  // Events are rising edges of the fault flags. The read data are caught
  // one edge before the taking edge, so a read clears only the bits it
  // returned; an event landing in between waits for the next read, and
  // an event in the taking cycle survives the clear.
  assign status_rd = bus_take & avs_read & (avs_address == `REG_STATUS_OFS);

  always @* begin
    status_nxt = status_r;
    if (status_rd) begin
      status_nxt = status_r & ~avs_readdata[3:0];
    end
    status_nxt = status_nxt | (flags & ~flags_d_r);
  end

  always @(posedge core_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      status_r  <= `RST_STATUS;
      flags_d_r <= 4'h0;
    end else begin
      status_r  <= status_nxt;
      flags_d_r <= flags;
    end
  end

  assign irq_o = |(status_r & mask_r);

endmodule
`default_nettype wire

// File: verification/bridge_chk.sv
/*
  Concurrent checks on the ports of bridge_ctrl.
  Assumes it is bound to every bridge_ctrl instance; single clock domain.
*/
`timescale 1ns/1ps
`default_nettype none
module bridge_chk (
  // Clock and reset
  input wire logic       core_clk_i,
  input wire logic       arst_n_i,
  // Host pins and comparators
  input wire logic       direction_input_a_i,
  input wire logic       direction_input_b_i,
  input wire logic       supply_below_low_i,
  input wire logic       supply_above_rec_i,
  input wire logic       supply_above_high_i,
  input wire logic       supply_below_rec_i,
  input wire logic       over_temp_i,
  input wire logic [3:0] over_current_i,
  // Gates and alert
  input wire logic       bridge_output_a_hi_o,
  input wire logic       bridge_output_a_lo_o,
  input wire logic       bridge_output_b_hi_o,
  input wire logic       bridge_output_b_lo_o,
  input wire logic       alert_o,
  input wire logic       alert_oe_o
);
  wire logic gates_off;
  wire logic stop;
  wire logic quiet;
  assign gates_off = !(bridge_output_a_hi_o | bridge_output_a_lo_o | bridge_output_b_hi_o | bridge_output_b_lo_o);
  assign stop = !direction_input_a_i && !direction_input_b_i;
  // Supplies between both recovery points and no cause present
  assign quiet = stop && !supply_below_low_i && supply_above_rec_i && !supply_above_high_i
                 && supply_below_rec_i && !over_temp_i && (over_current_i == 4'h0);

  default clocking @(posedge core_clk_i); endclocking
  default disable iff (!arst_n_i);

  a_alert_od: assert property (alert_o == 1'b0)
    else $error("alert data not low");
  a_normal_pull: assert property (quiet [*4] |-> alert_oe_o)
    else $error("alert not pulled low in normal operation");
  a_fault_release: assert property ((supply_below_low_i || supply_above_high_i || over_temp_i) |-> ##[1:3] !alert_oe_o)
    else $error("alert not released on fault");
  a_uv_off: assert property (supply_below_low_i |-> ##[1:4] gates_off)
    else $error("gates on under undervoltage");
  a_ov_off: assert property (supply_above_high_i |-> ##[1:4] gates_off)
    else $error("gates on under overvoltage");
  a_th_off: assert property (over_temp_i |-> ##[1:4] gates_off)
    else $error("gates on under overtemperature");
  a_th_hold: assert property (over_temp_i ##1 (!stop) [*4] |-> !alert_oe_o)
    else $error("thermal latch lost while driving");
  a_stop_off: assert property (stop [*4] |-> gates_off)
    else $error("gates on in stop");
  a_brake_no_hi: assert property ((direction_input_a_i && direction_input_b_i) [*4] |-> !bridge_output_a_hi_o && !bridge_output_b_hi_o)
    else $error("upper gate on in brake");
  a_no_shoot: assert property (!(bridge_output_a_hi_o && bridge_output_a_lo_o) && !(bridge_output_b_hi_o && bridge_output_b_lo_o))
    else $error("both gates of a leg on");
endmodule
bind bridge_ctrl bridge_chk bridge_chk_inst (.*);
`default_nettype wire

// File: verification/host_model.sv
/*
  Host controller model: turns a mode code into direction and speed pins,
  and reads the alert wire through its external pull-up.
  Assumes the bench changes mode_i just after a rising edge.
*/
`timescale 1ns/1ps
`default_nettype none
module host_model (
  // Clock
  input  wire logic       core_clk_i,
  // Command {a, b, speed}
  input  wire logic [2:0] mode_i,
  // Bridge pins
  output var  logic       dir_a_o,
  output var  logic       dir_b_o,
  output var  logic       speed_o,
  input  wire logic       alert_o,
  input  wire logic       alert_oe_o,
  output wire logic       alert_hi_o
);
  initial {dir_a_o, dir_b_o, speed_o} = 3'h0;
  // Pins move only at an edge, as a clocked host would
  always @(posedge core_clk_i) begin
    {dir_a_o, dir_b_o, speed_o} <= mode_i;
  end
  // A released line floats up through the pull-up
  assign alert_hi_o = alert_oe_o ? alert_o : 1'b1;
endmodule
`default_nettype wire

// File: verification/tb_bridge_ctrl.sv
/*
  Self-checking bench for bridge_ctrl: modes, dead gap, faults, registers.
  Assumes bridge_chk is bound and host_model drives the host pins.
*/
`timescale 1ns/1ps
`default_nettype none
`include "bridge_defs.vh"
module tb_bridge_ctrl;
  logic core_clk_i, arst_n_i, sbl, sar, sah, sbr, ot, rd, wr;
  logic [2:0] mode;
  logic [3:0] oc;
  logic [4:0] adr;
  logic [31:0] wd;
  wire logic dir_a, dir_b, spd, a_hi, a_lo, b_hi, b_lo, alert, alert_oe, alert_hi, irq, wreq;
  wire logic [31:0] rdat;
  wire logic [3:0] gates = {a_hi, a_lo, b_hi, b_lo};
  int mismatches = 0;
  int cmp_count = 0;

  bridge_ctrl bridge_ctrl_inst (.core_clk_i(core_clk_i), .arst_n_i(arst_n_i),
    .direction_input_a_i(dir_a), .direction_input_b_i(dir_b), .speed_i(spd),
    .supply_below_low_i(sbl), .supply_above_rec_i(sar), .supply_above_high_i(sah),
    .supply_below_rec_i(sbr), .over_temp_i(ot), .over_current_i(oc),
    .bridge_output_a_hi_o(a_hi), .bridge_output_a_lo_o(a_lo), .bridge_output_b_hi_o(b_hi),
    .bridge_output_b_lo_o(b_lo), .alert_o(alert), .alert_oe_o(alert_oe), .avs_address(adr),
    .avs_read(rd), .avs_write(wr), .avs_writedata(wd), .avs_readdata(rdat),
    .avs_waitrequest(wreq), .irq_o(irq));
  host_model host_model_inst (.core_clk_i(core_clk_i), .mode_i(mode), .dir_a_o(dir_a),
    .dir_b_o(dir_b), .speed_o(spd), .alert_o(alert), .alert_oe_o(alert_oe), .alert_hi_o(alert_hi));

  initial begin
    core_clk_i = 1'b0;
    forever #12.5 core_clk_i = ~core_clk_i;
  end

  task automatic test_done();
    $display("Comparisons %0d mismatches %0d", cmp_count, mismatches);
    if (mismatches == 0 && cmp_count > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    cmp_count++;
    if (g !== e) begin
      mismatches++;
      $display("MISMATCH %s expected %h seen %h", n, e, g);
    end
  endtask

  task automatic cyc(input int n);
    repeat (n) @(posedge core_clk_i);
  endtask

  // Holds the request until a rising edge sees waitrequest low, takes the
  // read data at that edge and only then releases the request
  task automatic bus(input logic w, input logic [4:0] a, input logic [31:0] d, output logic [31:0] q);
    @(posedge core_clk_i);
    adr <= a;
    wd <= d;
    rd <= !w;
    wr <= w;
    do @(posedge core_clk_i); while (wreq !== 1'b0);
    q = rdat;
    rd <= 1'b0;
    wr <= 1'b0;
  endtask

  task automatic t_regs();
    logic [31:0] q;
    bus(0, `REG_DEAD_OFS, 0, q);
    chk("dead_rst", `DEAD_TIME_CYC, q);
    bus(0, `REG_OCTIME_OFS, 0, q);
    chk("oc_rst", `OC_TIME_CYC, q);
    bus(0, `REG_MASK_OFS, 0, q);
    chk("mask_rst", 32'h0, q);
    bus(0, 5'h14, 0, q);
    chk("unmapped", 32'h0, q);
    bus(1, `REG_STATUS_OFS, 32'hf, q);
    bus(0, `REG_STATUS_OFS, 0, q);
    chk("status_ro", 32'h0, q);
    // Short counts keep the run brief
    bus(1, `REG_DEAD_OFS, 32'h2, q);
    bus(1, `REG_OCTIME_OFS, 32'h4, q);
    bus(1, `REG_MASK_OFS, 32'hf, q);
    bus(0, `REG_MASK_OFS, 0, q);
    chk("mask_rd", 32'hf, q);
  endtask

  task automatic t_modes();
    logic [3:0] tbl [8] = '{4'h0, 4'h0, 4'h5, 4'h6, 4'h5, 4'h9, 4'h5, 4'h5};
    for (int i = 0; i < 8; i++) begin
      @(posedge core_clk_i);
      mode <= i[2:0];
      cyc(10);
      chk("mode_gates", tbl[i], gates);
      chk("alert_normal", 1'b0, alert_hi);
    end
  endtask

  task automatic t_dead();
    int n = 0;
    @(posedge core_clk_i);
    mode <= 3'b101;
    repeat (12) begin
      @(negedge core_clk_i);
      if (!a_hi && !a_lo) n++;
    end
    chk("dead_gap", 32'd3, n);
    chk("fwd_gates", 4'h9, gates);
  endtask

  task automatic t_auto(input int k);
    logic [31:0] q;
    bus(0, `REG_STATUS_OFS, 0, q);
    @(posedge core_clk_i);
    sbl <= (k == 0);
    sar <= (k != 0);
    sah <= (k == 1);
    sbr <= (k != 1);
    cyc(3);
    sbl <= 1'b0;
    sah <= 1'b0;
    cyc(6);
    chk("supply_off", 4'h0, gates);
    chk("supply_alert", 1'b1, alert_hi);
    chk("irq_set", 1'b1, irq);
    bus(0, `REG_STATE_OFS, 0, q);
    chk("state_sup", 32'h100 | (32'h1 << k), q);
    bus(0, `REG_STATUS_OFS, 0, q);
    chk("status_sup", 32'h1 << k, q & 32'hf);
    cyc(1);
    chk("irq_clr", 1'b0, irq);
    sar <= 1'b1;
    sbr <= 1'b1;
    cyc(10);
    chk("supply_back", 4'h9, gates);
    chk("supply_alert_lo", 1'b0, alert_hi);
  endtask

  task automatic t_latch(input int k);
    logic [31:0] q;
    bus(0, `REG_STATUS_OFS, 0, q);
    bus(1, `REG_MASK_OFS, (k == 0) ? 32'h0 : 32'hf, q);
    if (k == 1) begin
      // Shorter than detection time: no latch
      oc <= 4'h2;
      cyc(3);
      oc <= 4'h0;
      cyc(4);
      chk("oc_short", 1'b0, alert_hi);
    end
    ot <= (k == 0);
    oc <= (k == 1) ? 4'h2 : 4'h0;
    cyc(8);
    ot <= 1'b0;
    oc <= 4'h0;
    cyc(6);
    chk("latch_off", 4'h0, gates);
    chk("latch_alert", 1'b1, alert_hi);
    chk("latch_irq", k, irq);
    bus(0, `REG_STATUS_OFS, 0, q);
    chk("status_lat", (k == 0) ? 32'h4 : 32'h8, q & 32'hf);
    mode <= 3'b000;
    cyc(6);
    chk("unlatch", 1'b0, alert_hi);
    mode <= 3'b101;
    cyc(10);
    chk("resume", 4'h9, gates);
  endtask

  initial begin
    arst_n_i = 1'b0;
    mode = 3'h0;
    {sbl, sah, ot, rd, wr} = 5'h0;
    {sar, sbr} = 2'h3;
    oc = 4'h0;
    adr = 5'h0;
    wd = 32'h0;
    cyc(2);
    arst_n_i <= 1'b1;
    t_regs();
    t_modes();
    t_dead();
    t_auto(0);
    t_auto(1);
    t_latch(0);
    t_latch(1);
    test_done();
  end

  // Whole run takes well under a thousand cycles
  initial begin
    #(25 * 5000);
    mismatches++;
    test_done();
  end
endmodule
`default_nettype wire
